/* design/lcf_consts.svh */
// constants for the logic cluster fabric: offsets, field positions, reset values
`ifndef LCF_CONSTS_SVH
`define LCF_CONSTS_SVH

// ----------------------------------------------------------------------------
// sizes
// ----------------------------------------------------------------------------
`define LCF_CELLS 8
`define LCF_ADDR_W 8
`define LCF_CTLS 4

// ----------------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------------
`define LCF_OFF_CELL0 8'h00
`define LCF_OFF_CELL_LAST 8'h1c
`define LCF_OFF_CTRL 8'h20
`define LCF_OFF_STAT 8'h24

// ----------------------------------------------------------------------------
// cell configuration word
// ----------------------------------------------------------------------------
`define LCF_F_LUT 15:0
`define LCF_F_LUT_LO 7:0
`define LCF_F_LUT_HI 15:8
`define LCF_F_MODE 17:16
`define LCF_F_FFT 19:18
`define LCF_B_LSEL 20
`define LCF_B_RSEL 21
`define LCF_B_CKSEL 22
`define LCF_B_CEEN 23
`define LCF_F_CPM 26:24
`define LCF_B_CASOR 27
`define LCF_B_CASUSE 28
`define LCF_B_CARUSE 29
`define LCF_B_PACK 30

// ----------------------------------------------------------------------------
// cluster control word: four 5-bit source selects, then flags
// ----------------------------------------------------------------------------
`define LCF_SRC_W 5
`define LCF_F_SRC_SEL 4:3
`define LCF_F_SRC_IDX 2:0
`define LCF_F_INV 23:20
`define LCF_B_START 24
`define LCF_B_END 25
`define LCF_B_GRST 26
`define LCF_B_RUN 27

// ----------------------------------------------------------------------------
// status word
// ----------------------------------------------------------------------------
`define LCF_F_ST_Q 7:0
`define LCF_F_ST_LOC 15:8
`define LCF_F_ST_ROW 23:16
`define LCF_B_ST_COUT 24
`define LCF_B_ST_CASO 25
`define LCF_B_ST_FINAL 26

// ----------------------------------------------------------------------------
// reset values and bus answers
// ----------------------------------------------------------------------------
`define LCF_CELL_RST 32'h0000_0000
`define LCF_CTRL_RST 32'h0000_0000
`define LCF_RESP_OKAY 2'h0
`define LCF_RESP_SLVERR 2'h2
`define LCF_DEC_CTRL 4'h8
`define LCF_DEC_STAT 4'h9
`define LCF_DEC_BAD 4'hf

`endif

/* design/lcf_pkg.sv */
// types shared by the logic cluster fabric modules
package lcf_pkg;

  typedef enum logic [1:0] {
    LCF_MODE_NORMAL = 2'h0,
    LCF_MODE_ARITH = 2'h1,
    LCF_MODE_UPDN = 2'h2,
    LCF_MODE_CLRCNT = 2'h3
  } lcf_mode_t;

  typedef enum logic [1:0] {
    LCF_FF_D = 2'h0,
    LCF_FF_T = 2'h1,
    LCF_FF_JK = 2'h2,
    LCF_FF_SR = 2'h3
  } lcf_fft_t;

  typedef enum logic [2:0] {
    LCF_CP_CLR = 3'h0,
    LCF_CP_PRE = 3'h1,
    LCF_CP_CLR_PRE = 3'h2,
    LCF_CP_LD_CLR = 3'h3,
    LCF_CP_LD_PRE = 3'h4,
    LCF_CP_LD = 3'h5
  } lcf_cpm_t;

  typedef enum logic [1:0] {
    LCF_SRC_DED = 2'h0,
    LCF_SRC_GLB = 2'h1,
    LCF_SRC_IO = 2'h2,
    LCF_SRC_INT = 2'h3
  } lcf_src_t;

  typedef struct packed {
    logic [1:0] clk_lvl;
  } lcf_ctrl_st_t;

  typedef struct packed {
    logic [7:0][31:0] cell_cfg;
    logic [31:0] ctrl;
    logic [7:0] q;
    logic [7:0] loc;
    logic [7:0] row;
    logic cout;
    logic caso;
    logic final_c;
    logic [7:0] aw_addr;
    logic aw_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic w_got;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } lcf_top_st_t;

endpackage

/* design/lcf_ctl_if.sv */
// shared cluster control lines passed from the selector to the cells
`timescale 1ns/1ps
interface lcf_ctl_if;
  logic [1:0] clk_tick;
  logic [1:0] ctl_n;
  modport src (output clk_tick, output ctl_n);
  modport snk (input clk_tick, input ctl_n);
endinterface

/* design/lcf_ctrl.sv */
// cluster control line selection, inversion and clock edge detection
`timescale 1ns/1ps
`include "lcf_consts.svh"
module lcf_ctrl (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic [31:0] ctrl_cfg,
  input wire logic [1:0] ded_clk,
  input wire logic [3:0] glb_sig,
  input wire logic [3:0] io_sig,
  input wire logic [7:0] fab_sig,
  lcf_ctl_if.src ctl
);
  lcf_pkg::lcf_ctrl_st_t s_r;
  lcf_pkg::lcf_ctrl_st_t s_nxt;
  logic [3:0] lvl;
  logic [3:0] inv;

  // one selected control line; the caller applies the inversion
  function automatic logic pick(input logic [4:0] sel, input logic [1:0] dd,
                                input logic [3:0] g, input logic [3:0] io,
                                input logic [7:0] f, input logic is_clk);
    logic r;
    r = 1'b1;
    case (lcf_pkg::lcf_src_t'(sel[`LCF_F_SRC_SEL]))
      lcf_pkg::LCF_SRC_DED: r = is_clk ? dd[sel[0]] : f[sel[`LCF_F_SRC_IDX]];
      lcf_pkg::LCF_SRC_GLB: r = g[sel[1:0]];
      lcf_pkg::LCF_SRC_IO: r = io[sel[1:0]];
      lcf_pkg::LCF_SRC_INT: r = f[sel[`LCF_F_SRC_IDX]];
      default: r = 1'b1;
    endcase
    return r;
  endfunction

  always_comb begin
    inv = ctrl_cfg[`LCF_F_INV];
    for (int i = 0; i < `LCF_CTLS; i++) begin
      // clear/preset lines have no dedicated clock pin source; that code falls to fabric
      lvl[i] = pick(ctrl_cfg[i*`LCF_SRC_W +: `LCF_SRC_W], ded_clk, glb_sig, io_sig,
                    fab_sig, (i < 2)) ^ inv[i];
    end
    s_nxt = s_r;
    s_nxt.clk_lvl = lvl[1:0];
    // cluster clocks act as rising-edge ticks in the core clock domain
    ctl.clk_tick = lvl[1:0] & ~s_r.clk_lvl;
    ctl.ctl_n = lvl[3:2];
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      s_r <= '0;
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end
endmodule

/* design/lcf_cell.sv */
// one logic cell: lookup table, carry and cascade stage, register next state
`timescale 1ns/1ps
`include "lcf_consts.svh"
module lcf_cell (
  input wire logic [31:0] cfg,
  input wire logic [3:0] din,
  input wire logic q,
  input wire logic cin,
  input wire logic casin,
  input wire logic run,
  input wire logic grst_n,
  lcf_ctl_if.snk ctl,
  output logic lut_o,
  output logic cout,
  output logic casout,
  output logic q_nxt
);
  lcf_pkg::lcf_mode_t mode;
  logic [2:0] i3;
  logic f, cas_eff, comb, dd, fn, en, qs, c1, c2, clr, pre, ld;

  always_comb begin
    mode = lcf_pkg::lcf_mode_t'(cfg[`LCF_F_MODE]);
    i3 = (mode == lcf_pkg::LCF_MODE_ARITH) ? {cin, din[1], din[0]} : {cin, q, din[1]};
    cout = 1'(cfg[`LCF_F_LUT_HI] >> i3);
    case (mode)
      lcf_pkg::LCF_MODE_NORMAL: begin
        f = cfg[{din[3], cfg[`LCF_B_CARUSE] ? cin : din[2], din[1], din[0]}];
        cout = cin;
      end
      lcf_pkg::LCF_MODE_ARITH: f = cfg[i3];
      lcf_pkg::LCF_MODE_UPDN: f = din[2] ? din[3] : cfg[i3];
      lcf_pkg::LCF_MODE_CLRCNT: f = (din[2] ? din[3] : cfg[i3]) & casin;
      default: f = 1'b0;
    endcase
    // unused cascade input is forced to the neutral value of the chosen gate
    cas_eff = cfg[`LCF_B_CASUSE] ? casin : ~cfg[`LCF_B_CASOR];
    comb = cfg[`LCF_B_CASOR] ? ~(~f & ~cas_eff) : (f & cas_eff);
    if (mode == lcf_pkg::LCF_MODE_CLRCNT) begin
      comb = f;
    end
    lut_o = comb;
    casout = comb;
    dd = cfg[`LCF_B_PACK] ? din[3] : comb;
    case (lcf_pkg::lcf_fft_t'(cfg[`LCF_F_FFT]))
      lcf_pkg::LCF_FF_D: fn = dd;
      lcf_pkg::LCF_FF_T: fn = q ^ dd;
      lcf_pkg::LCF_FF_JK: fn = q ? ~din[3] : dd;
      lcf_pkg::LCF_FF_SR: fn = dd ? 1'b1 : (din[3] ? 1'b0 : q);
      default: fn = dd;
    endcase
    en = ctl.clk_tick[cfg[`LCF_B_CKSEL]] & (~cfg[`LCF_B_CEEN] | din[0]);
    qs = en ? fn : q;
    c1 = ~ctl.ctl_n[0];
    c2 = ~ctl.ctl_n[1];
    clr = 1'b0;
    pre = 1'b0;
    ld = 1'b0;
    case (lcf_pkg::lcf_cpm_t'(cfg[`LCF_F_CPM]))
      lcf_pkg::LCF_CP_CLR: clr = c1 | c2;
      lcf_pkg::LCF_CP_PRE: pre = c1;
      lcf_pkg::LCF_CP_CLR_PRE: begin
        pre = c1;
        clr = c2;
      end
      lcf_pkg::LCF_CP_LD_CLR: begin
        ld = c1;
        clr = c2;
      end
      lcf_pkg::LCF_CP_LD_PRE: begin
        ld = c1;
        pre = c2;
      end
      lcf_pkg::LCF_CP_LD: ld = c1;
      default: clr = 1'b0;
    endcase
    if (!run) begin
      q_nxt = q;
    end else if (!grst_n) begin
      q_nxt = 1'b0;
    end else if (clr) begin
      q_nxt = 1'b0;
    end else if (pre) begin
      q_nxt = 1'b1;
    end else if (ld) begin
      q_nxt = din[2];
    end else begin
      q_nxt = qs;
    end
  end
endmodule

/* design/lcf_cluster.sv */
// logic cluster of eight cells with chains, shared controls and an AXI4-Lite config port
//
// Functional notes
// - a cluster holds eight cells, their chains, shared controls and local routing
// - four shared control lines, each invertible, usable by all eight cells
// - two control lines act as clocks, two as clear or preset
// - clocks from dedicated, global, I/O or internal; clears from global, I/O, internal
// - every cell has a four-input lookup table for any function
// - each cell register has a synchronous clock enable honoured on clock edges
// - the cell register behaves as D, T, JK or SR type
// - combinational use bypasses the register; table result drives the output
// - two independently selected outputs, local and row, table or register
// - carry in feeds the table and continues to the next higher cell
// - carry beyond eight cells continues to a same-parity cluster two along
// - carry stops at the row's memory block; a new chain starts past it
// - the final carry out reaches a cell as a general-purpose signal
// - cascade combines adjacent table outputs by AND, or OR through inversion
// - each added cascade cell widens the function by four inputs
// - cascade beyond eight cells continues to a same-parity cluster two along
// - cascade stops at the row centre memory block; a new one starts beyond
// - each cell offers normal, arithmetic, up/down and clearable counter modes
// - seven inputs routed by mode: four data, feedback, carry in, cascade in
// - three cell inputs supply register clock, clear and preset
// - clock enable in every mode; first data input can serve as enable
// - clear and preset are active low; unused ones sit high
// - enabled device-wide reset clears all registers over every other control; here registers hold while the run bit is 0
//
// The implementer's own choices: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "lcf_consts.svh"
module lcf_cluster (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic ce,
  // ---------------------------------------------------------------------------
  // axi4-lite slave
  // ---------------------------------------------------------------------------
  input wire logic [`LCF_ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [`LCF_ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // ---------------------------------------------------------------------------
  // fabric side
  // ---------------------------------------------------------------------------
  input wire logic [31:0] cell_data_in,
  input wire logic [1:0] ded_clk,
  input wire logic [3:0] glb_sig,
  input wire logic [3:0] io_sig,
  input wire logic chip_rst_n,
  input wire logic carry_in,
  input wire logic cascade_in,
  output logic carry_out,
  output logic cascade_out,
  output logic carry_final,
  output logic [7:0] local_out,
  output logic [7:0] row_out
);

  // ---------------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------------
  lcf_pkg::lcf_top_st_t s_r;
  lcf_pkg::lcf_top_st_t s_nxt;

  logic [`LCF_CELLS:0] carry_c;
  logic [`LCF_CELLS:0] cas_c;
  logic [7:0] lut_v;
  logic [7:0] q_v;
  logic [3:0] wsel;
  logic [3:0] rsel;
  logic [31:0] stat_w;
  logic grst_n;
  logic run;

  lcf_ctl_if ctl_bus ();

  // ---------------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------------
  // map a byte address to a cell index, the control word, status or a miss
  function automatic logic [3:0] dec(input logic [`LCF_ADDR_W-1:0] a);
    logic [3:0] r;
    r = `LCF_DEC_BAD;
    if (a[1:0] != 2'h0) begin
      r = `LCF_DEC_BAD;
    end else if (a <= `LCF_OFF_CELL_LAST) begin
      r = {1'b0, a[4:2]};
    end else if (a == `LCF_OFF_CTRL) begin
      r = `LCF_DEC_CTRL;
    end else if (a == `LCF_OFF_STAT) begin
      r = `LCF_DEC_STAT;
    end
    return r;
  endfunction

  // byte-lane merge under write strobes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = d[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // ---------------------------------------------------------------------------
  // control line selection
  // ---------------------------------------------------------------------------
  // register-sourced fabric feedback avoids a combinational loop through the cells
  lcf_ctrl u_ctrl (
    .core_clk(core_clk),
    .nrst(nrst),
    .ce(ce),
    .ctrl_cfg(s_r.ctrl),
    .ded_clk(ded_clk),
    .glb_sig(glb_sig),
    .io_sig(io_sig),
    .fab_sig(s_r.loc),
    .ctl(ctl_bus.src)
  );

  // ---------------------------------------------------------------------------
  // cells and chains
  // ---------------------------------------------------------------------------
  assign run = s_r.ctrl[`LCF_B_RUN];
  assign grst_n = chip_rst_n | ~s_r.ctrl[`LCF_B_GRST];
  assign q_v = s_r.q;

  // a chain start isolates this cluster from the far side of the memory block
  assign carry_c[0] = s_r.ctrl[`LCF_B_START] ? 1'b0 : carry_in;
  assign cas_c[0] = s_r.ctrl[`LCF_B_START] ?
                    ~s_r.cell_cfg[0][`LCF_B_CASOR] : cascade_in;

  for (genvar i = 0; i < `LCF_CELLS; i++) begin : g_cell
    logic qn;
    lcf_cell u_cell (
      .cfg(s_r.cell_cfg[i]),
      .din(cell_data_in[i*4 +: 4]),
      .q(q_v[i]),
      .cin(carry_c[i]),
      .casin(cas_c[i]),
      .run(run),
      .grst_n(grst_n),
      .ctl(ctl_bus.snk),
      .lut_o(lut_v[i]),
      .cout(carry_c[i+1]),
      .casout(cas_c[i+1]),
      .q_nxt(qn)
    );
  end

  // ---------------------------------------------------------------------------
  // status word
  // ---------------------------------------------------------------------------
  always_comb begin
    stat_w = '0;
    stat_w[`LCF_F_ST_Q] = s_r.q;
    stat_w[`LCF_F_ST_LOC] = s_r.loc;
    stat_w[`LCF_F_ST_ROW] = s_r.row;
    stat_w[`LCF_B_ST_COUT] = s_r.cout;
    stat_w[`LCF_B_ST_CASO] = s_r.caso;
    stat_w[`LCF_B_ST_FINAL] = s_r.final_c;
  end

  // ---------------------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;

    // cell registers
    for (int i = 0; i < `LCF_CELLS; i++) begin
      s_nxt.q[i] = 1'b0;
    end
    s_nxt.q = {g_cell[7].qn, g_cell[6].qn, g_cell[5].qn, g_cell[4].qn,
               g_cell[3].qn, g_cell[2].qn, g_cell[1].qn, g_cell[0].qn};

    // cell outputs, each picking table or register on its own
    for (int i = 0; i < `LCF_CELLS; i++) begin
      s_nxt.loc[i] = s_r.cell_cfg[i][`LCF_B_LSEL] ? s_r.q[i] : lut_v[i];
      s_nxt.row[i] = s_r.cell_cfg[i][`LCF_B_RSEL] ? s_r.q[i] : lut_v[i];
    end

    // chain ends: the last cell before the memory block keeps its carry local
    if (s_r.ctrl[`LCF_B_END]) begin
      s_nxt.cout = 1'b0;
      s_nxt.caso = 1'b0;
      s_nxt.final_c = carry_c[`LCF_CELLS];
    end else begin
      s_nxt.cout = carry_c[`LCF_CELLS];
      s_nxt.caso = cas_c[`LCF_CELLS];
      s_nxt.final_c = 1'b0;
    end

    // write address and data are taken independently, in either order
    if (awvalid && s_r.awready) begin
      s_nxt.aw_addr = awaddr;
      s_nxt.aw_got = 1'b1;
    end
    if (wvalid && s_r.wready) begin
      s_nxt.w_data = wdata;
      s_nxt.w_strb = wstrb;
      s_nxt.w_got = 1'b1;
    end
    if (s_r.bvalid && bready) begin
      s_nxt.bvalid = 1'b0;
    end

    wsel = dec(s_nxt.aw_addr);
    if (s_nxt.aw_got && s_nxt.w_got && !s_nxt.bvalid) begin
      s_nxt.bresp = `LCF_RESP_OKAY;
      if (wsel == `LCF_DEC_CTRL) begin
        s_nxt.ctrl = merge(s_r.ctrl, s_nxt.w_data, s_nxt.w_strb);
      end else if (wsel == `LCF_DEC_STAT) begin
        // status is read only; the write is accepted and dropped
        s_nxt.bresp = `LCF_RESP_OKAY;
      end else if (wsel == `LCF_DEC_BAD) begin
        s_nxt.bresp = `LCF_RESP_SLVERR;
      end else begin
        s_nxt.cell_cfg[wsel[2:0]] = merge(s_r.cell_cfg[wsel[2:0]], s_nxt.w_data,
                                          s_nxt.w_strb);
      end
      s_nxt.bvalid = 1'b1;
      s_nxt.aw_got = 1'b0;
      s_nxt.w_got = 1'b0;
    end
    s_nxt.awready = ~s_nxt.aw_got & ~s_nxt.bvalid;
    s_nxt.wready = ~s_nxt.w_got & ~s_nxt.bvalid;

    // read channel: one outstanding read, answered one cycle after acceptance
    if (s_r.rvalid && rready) begin
      s_nxt.rvalid = 1'b0;
    end
    rsel = dec(araddr);
    if (arvalid && s_r.arready) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp = `LCF_RESP_OKAY;
      if (rsel == `LCF_DEC_CTRL) begin
        s_nxt.rdata = s_r.ctrl;
      end else if (rsel == `LCF_DEC_STAT) begin
        s_nxt.rdata = stat_w;
      end else if (rsel == `LCF_DEC_BAD) begin
        s_nxt.rdata = '0;
        s_nxt.rresp = `LCF_RESP_SLVERR;
      end else begin
        s_nxt.rdata = s_r.cell_cfg[rsel[2:0]];
      end
    end
    s_nxt.arready = ~s_nxt.rvalid;
  end

  // ---------------------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      s_r <= '0;
      s_r.cell_cfg <= {`LCF_CELLS{`LCF_CELL_RST}};
      s_r.ctrl <= `LCF_CTRL_RST;
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  // ---------------------------------------------------------------------------
  // outputs, all straight from flip-flops
  // ---------------------------------------------------------------------------
  // trade-off: the table result reaches the pins one core cycle late
  assign awready = s_r.awready;
  assign wready = s_r.wready;
  assign bvalid = s_r.bvalid;
  assign bresp = s_r.bresp;
  assign arready = s_r.arready;
  assign rvalid = s_r.rvalid;
  assign rdata = s_r.rdata;
  assign rresp = s_r.rresp;
  assign local_out = s_r.loc;
  assign row_out = s_r.row;
  assign carry_out = s_r.cout;
  assign cascade_out = s_r.caso;
  assign carry_final = s_r.final_c;

endmodule

/* testbench/lcf_nbr.sv */
// neighbour fabric model: dedicated clock source and global control lines
`timescale 1ns/1ps
module lcf_nbr (
  input wire logic core_clk,
  input wire logic run_clk,
  input wire logic clr_req,
  output logic [1:0] ded_clk,
  output logic [3:0] glb_sig,
  output logic [3:0] io_sig
);
  // ---------------------------------------------------------------------------
  // sources
  // ---------------------------------------------------------------------------
  logic [1:0] div_r = 2'h0;
  // clock line stands still unless clocking is asked for
  always @(posedge core_clk) begin
    div_r <= run_clk ? div_r + 2'h1 : 2'h0;
  end
  assign ded_clk = {1'b0, div_r[1]};
  // unused clears sit high; low only on request
  assign glb_sig = {3'h7, !clr_req};
  assign io_sig = 4'hf;
endmodule

/* testbench/lcf_cluster_asserts.sv */
// protocol checker for the cluster configuration port
`timescale 1ns/1ps
`include "lcf_consts.svh"
module lcf_cluster_chk (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic [`LCF_ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [`LCF_ADDR_W-1:0] araddr,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  input wire logic rready
);
  // ---------------------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst || !ce);
  logic bad_aw;
  logic bad_ar;
  // unaligned or past the status word gets an error
  assign bad_aw = awaddr[1:0] != 2'h0 || awaddr > 8'h24;
  assign bad_ar = araddr[1:0] != 2'h0 || araddr > 8'h24;
  sequence s_wr_take;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence s_rd_take;
    arvalid && arready;
  endsequence
  property p_b_ans;
    s_wr_take |=> bvalid && bresp == ($past(bad_aw) ? 2'h2 : 2'h0);
  endproperty
  property p_r_ans;
    s_rd_take |=> rvalid && rresp == ($past(bad_ar) ? 2'h2 : 2'h0)
      && (!$past(bad_ar) || rdata == 32'h0);
  endproperty
  property p_b_hold;
    bvalid && !bready |=> bvalid && $stable(bresp);
  endproperty
  property p_r_hold;
    rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp);
  endproperty
  property p_w_block;
    bvalid |-> !awready && !wready;
  endproperty
  property p_ar_block;
    rvalid |-> !arready;
  endproperty
  property p_b_back;
    bvalid && bready |=> !bvalid && awready && wready;
  endproperty
  property p_r_back;
    rvalid && rready |=> !rvalid && arready;
  endproperty
  a_b_ans: assert property (p_b_ans) else $error("write answer wrong");
  a_r_ans: assert property (p_r_ans) else $error("read answer wrong");
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
  a_w_block: assert property (p_w_block) else $error("write taken early");
  a_ar_block: assert property (p_ar_block) else $error("read taken early");
  a_b_back: assert property (p_b_back) else $error("write not reopened");
  a_r_back: assert property (p_r_back) else $error("read not reopened");
endmodule

bind lcf_cluster lcf_cluster_chk u_chk (.core_clk, .nrst, .ce, .awaddr, .awvalid,
  .awready, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
  .rdata, .rresp, .rvalid, .rready);

/* testbench/tb_lcf_cluster.sv */
// self-checking bench for the logic cluster
`timescale 1ns/1ps
module tb_lcf_cluster;
  // ---------------------------------------------------------------------------
  // signals and design
  // ---------------------------------------------------------------------------
  logic core_clk, awready, wready, bvalid, arready, rvalid;
  logic carry_out, cascade_out, carry_final;
  logic [1:0] bresp, rresp, ded_clk;
  logic [31:0] rdata;
  logic [7:0] local_out, row_out;
  logic [3:0] glb_sig, io_sig;
  logic nrst = 1'b0, ce = 1'b1, chip_rst_n = 1'b1, carry_in = 1'b0, cascade_in = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic run_clk = 1'b0, clr_req = 1'b0;
  logic [7:0] awaddr = 8'h0, araddr = 8'h0;
  logic [31:0] wdata = 32'h0, cell_data_in = 32'h0;
  logic [3:0] wstrb = 4'hf;
  int errors = 0, num_checks = 0;

  lcf_cluster u_dut (.core_clk, .nrst, .ce, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready, .cell_data_in, .ded_clk, .glb_sig, .io_sig, .chip_rst_n,
    .carry_in, .cascade_in, .carry_out, .cascade_out, .carry_final, .local_out, .row_out);
  lcf_nbr u_nbr (.core_clk, .run_clk, .clr_req, .ded_clk, .glb_sig, .io_sig);

  // ---------------------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------------------
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // ready is raised late so the answer must stand a cycle
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge core_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge core_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) bready <= 1'b1;
    end while (!(bvalid === 1'b1 && bready));
    bready <= 1'b0;
    chk(32'(bresp), 32'(er));
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge core_clk);
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge core_clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) rready <= 1'b1;
    end while (!(rvalid === 1'b1 && rready));
    rready <= 1'b0;
    chk(rdata, ed);
    chk(32'(rresp), 32'(er));
  endtask

  // ---------------------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------------------
  task automatic t_regs;
    for (int i = 0; i < 10; i++) rd(8'(4 * i), 32'h0, 2'h0);
    rd(8'h28, 32'h0, 2'h2);
    rd(8'h02, 32'h0, 2'h2);
    wr(8'h30, 32'hffff_ffff, 2'h2);
    wr(8'h24, 32'hffff_ffff, 2'h0);
    for (int m = 0; m < 4; m++) begin
      wr(8'h04, {12'h0, 2'(m), 2'(m), 16'h0}, 2'h0);
      rd(8'h04, {12'h0, 2'(m), 2'(m), 16'h0}, 2'h0);
    end
    wr(8'h04, 32'h0, 2'h0);
    $display("test regs done");
  endtask
  // local shows the table, row shows the idle register
  task automatic t_lut;
    logic [15:0] tbl = 16'h6996;
    wr(8'h00, {16'h0020, tbl}, 2'h0);
    for (int d = 0; d < 16; d++) begin
      cell_data_in <= 32'(d);
      step(3);
      chk(32'({row_out[0], local_out[0]}), 32'(tbl[d]));
    end
    wr(8'h00, 32'h0001_e896, 2'h0);
    cell_data_in <= 32'h3;
    step(3);
    chk(32'({carry_out, local_out[0]}), 32'h2);
    $display("test lut done");
  endtask
  task automatic t_chain;
    for (int k = 0; k < 4; k++) begin
      for (int i = 0; i < 8; i++) begin
        wr(8'(4 * i), {3'h0, 1'b1, k[1], 11'h0, {16{k[0]}}}, 2'h0);
      end
      cascade_in <= !k[1];
      carry_in <= k[0];
      step(3);
      chk(32'({cascade_out, carry_out}), {30'h0, k[0], k[0]});
    end
    wr(8'h20, 32'h0200_0000, 2'h0);
    step(3);
    chk(32'({carry_final, cascade_out, carry_out}), 32'h4);
    wr(8'h20, 32'h0100_0000, 2'h0);
    step(3);
    chk(32'({carry_final, cascade_out, carry_out}), 32'h2);
    $display("test chain done");
  endtask
  task automatic t_ff;
    wr(8'h00, 32'h0090_ff00, 2'h0);
    wr(8'h20, 32'h0c04_2000, 2'h0);
    run_clk <= 1'b1;
    cell_data_in <= 32'h8;
    step(12);
    chk(32'(local_out[0]), 32'h0);
    cell_data_in <= 32'h9;
    step(12);
    chk(32'(local_out[0]), 32'h1);
    chip_rst_n <= 1'b0;
    step(12);
    chk(32'(local_out[0]), 32'h0);
    chip_rst_n <= 1'b1;
    step(12);
    chk(32'(local_out[0]), 32'h1);
    clr_req <= 1'b1;
    step(12);
    chk(32'(local_out[0]), 32'h0);
    clr_req <= 1'b0;
    run_clk <= 1'b0;
    $display("test register done");
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------------------
  // run
  // ---------------------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  initial begin
    repeat (8) @(posedge core_clk);
    nrst <= 1'b1;
    step(2);
    t_regs;
    t_lut;
    t_chain;
    t_ff;
    close_out;
  end
  // whole run is well under a thousand cycles
  initial begin
    repeat (4000) @(posedge core_clk);
    errors++;
    close_out;
  end
endmodule
